// [hw/rsf_pkg.sv]
package rsf_pkg;

  // Clock and delay timing
  localparam int unsigned CLK_PERIOD_NS  = 100;
  localparam int unsigned RSTD_LONG_NS   = 48_000_000;
  localparam int unsigned RSTD_SHORT_NS  = 16_000_000;
  localparam int unsigned SRESET_NS      = 800;
  localparam int unsigned RSTD_LONG_CYC  = RSTD_LONG_NS / CLK_PERIOD_NS;
  localparam int unsigned RSTD_SHORT_CYC = RSTD_SHORT_NS / CLK_PERIOD_NS;
  localparam int unsigned SRESET_CYC     = (SRESET_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // Register offsets
  localparam logic [7:0] ADDR_FLAGS  = 8'h00;
  localparam logic [7:0] ADDR_VSEL   = 8'h01;
  localparam logic [7:0] ADDR_RCTRL  = 8'h02;
  localparam logic [7:0] ADDR_STATUS = 8'h03;

  // Flag field positions
  localparam int unsigned FLAG_WIDTH       = 4;
  localparam int unsigned FLAG_WD_CTRL     = 0;
  localparam int unsigned FLAG_BAD_VSEL    = 1;
  localparam int unsigned FLAG_LOW_SUPPLY  = 2;
  localparam int unsigned FLAG_CTRL_VALUE  = 3;
  localparam logic [3:0]  FLAGS_POR        = 4'h0;

  // Status field positions
  localparam int unsigned STATUS_PWRDN_BIT   = 4;
  localparam int unsigned STATUS_EXPIRED_BIT = 5;

  // Voltage select codes
  localparam logic [7:0] VSEL_POR  = 8'h55;
  localparam logic [7:0] VSEL_LVL0 = 8'h55;
  localparam logic [7:0] VSEL_LVL1 = 8'h33;
  localparam logic [7:0] VSEL_LVL2 = 8'h99;
  localparam logic [7:0] VSEL_LVL3 = 8'haa;

  // Reset function control codes
  localparam logic [7:0] RCTRL_POR = 8'h55;
  localparam logic [7:0] RCTRL_IO  = 8'h55;
  localparam logic [7:0] RCTRL_PIN = 8'haa;

  typedef enum logic [2:0] {
    RSF_RUN   = 3'b001,
    RSF_DELAY = 3'b010,
    RSF_HOLD  = 3'b100
  } rsf_state_type;

endpackage : rsf_pkg

// [hw/rsf_reset_flags.sv]
`timescale 1ns/100ps

module rsf_reset_flags #(
  parameter int unsigned LONG_HOLD_CYCLES  = rsf_pkg::RSTD_LONG_CYC,
  parameter int unsigned SHORT_HOLD_CYCLES = rsf_pkg::RSTD_SHORT_CYC,
  parameter int unsigned SRESET_CYCLES     = rsf_pkg::SRESET_CYC
) (
  input  wire logic       clk,
  input  wire logic       arst_n,
  input  wire logic       clkEn,
  input  wire logic [7:0] regAddr,
  input  wire logic [7:0] regWrData,
  input  wire logic       regWrite,
  input  wire logic       regRead,
  output logic      [7:0] regRdData,
  input  wire logic       externalResetPin_n,
  input  wire logic       lowSupplyReset,
  input  wire logic       watchdogTimeout,
  input  wire logic       watchdogCtrlFault,
  input  wire logic       idleSleepMode,
  input  wire logic       statusClear,
  output logic            resetPinSelected,
  output logic            fullReset,
  output logic            pcLowClear,
  output logic            stackPtrClear,
  output logic            wdtRestart,
  output logic            watchdogExpiredFlag,
  output logic            powerDownFlag
);

  localparam logic [19:0] LONG_LAST   = 20'(LONG_HOLD_CYCLES - 1);
  localparam logic [19:0] SHORT_LAST  = 20'(SHORT_HOLD_CYCLES - 1);
  localparam logic [19:0] SRESET_LAST = 20'(SRESET_CYCLES - 1);

  function automatic logic rsf_vsel_ok(input logic [7:0] code);
    rsf_vsel_ok = (code == rsf_pkg::VSEL_LVL0) || (code == rsf_pkg::VSEL_LVL1) ||
                  (code == rsf_pkg::VSEL_LVL2) || (code == rsf_pkg::VSEL_LVL3);
  endfunction : rsf_vsel_ok

  function automatic logic rsf_hit(input logic strobe, input logic [7:0] addr,
                                   input logic [7:0] target);
    rsf_hit = strobe && (addr == target);
  endfunction : rsf_hit

  rsf_pkg::rsf_state_type state_q;
  rsf_pkg::rsf_state_type state_d;
  logic [19:0]            cnt_q;
  logic [19:0]            cnt_d;
  logic                   holdLong_q;
  logic                   holdLong_d;
  logic [3:0]             flags_q;
  logic [3:0]             flags_d;
  logic [7:0]             vsel_q;
  logic [7:0]             vsel_d;
  logic [7:0]             rctrl_q;
  logic [7:0]             rctrl_d;
  logic                   expired_q;
  logic                   powerDown_q;
  logic                   warmPulse_q;
  logic                   restart_q;
  logic [7:0]             rdData_q;
  logic [1:0]             pinSync_q;
  logic [1:0]             lowSync_q;

  // Pin and analog inputs cross into clk through two stages
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      pinSync_q <= 2'h3;
      lowSync_q <= 2'h0;
    end else if (clkEn) begin
      pinSync_q <= {pinSync_q[0], externalResetPin_n};
      lowSync_q <= {lowSync_q[0], lowSupplyReset};
    end
  end

  wire running      = (state_q == rsf_pkg::RSF_RUN);
  wire holding      = (state_q == rsf_pkg::RSF_HOLD);
  wire vselBad      = !rsf_vsel_ok(vsel_q);
  wire rctrlBad     = (rctrl_q != rsf_pkg::RCTRL_IO) && (rctrl_q != rsf_pkg::RCTRL_PIN);
  wire pinSelected  = (rctrl_q == rsf_pkg::RCTRL_PIN);
  wire pinReset     = pinSelected && !pinSync_q[1];
  // Supply monitor is off in power down, so ignore it there
  wire lowSupplyHit = lowSync_q[1] && !idleSleepMode;
  // Normal timeout is a hard cause
  wire wdtNormal    = watchdogTimeout && !idleSleepMode;
  wire wdtWarm      = watchdogTimeout && idleSleepMode;
  wire hardCause    = lowSupplyHit || pinReset || wdtNormal;
  wire softCause    = vselBad || rctrlBad || watchdogCtrlFault;
  // Pin reset outranks a warm timeout
  wire warmHit      = running && wdtWarm && !pinReset;
  wire wrFlags      = rsf_hit(regWrite, regAddr, rsf_pkg::ADDR_FLAGS);
  wire wrVsel       = rsf_hit(regWrite, regAddr, rsf_pkg::ADDR_VSEL);
  wire wrRctrl      = rsf_hit(regWrite, regAddr, rsf_pkg::ADDR_RCTRL);
  wire enterHold    = (state_d == rsf_pkg::RSF_HOLD) && !holding;
  // Twenty bits cover the long hold count
  wire [19:0] holdLast = holdLong_q ? LONG_LAST : SHORT_LAST;

  // Sequencer: run, software reset delay, reset hold
  always_comb begin
    state_d    = state_q;
    cnt_d      = cnt_q;
    holdLong_d = holdLong_q;
    unique case (state_q)
      rsf_pkg::RSF_RUN: begin
        if (hardCause) begin
          state_d    = rsf_pkg::RSF_HOLD;
          cnt_d      = 20'h0;
          holdLong_d = lowSupplyHit;
        end else if (softCause) begin
          state_d = rsf_pkg::RSF_DELAY;
          cnt_d   = 20'h0;
        end
      end
      rsf_pkg::RSF_DELAY: begin
        if (lowSupplyHit || cnt_q == SRESET_LAST) begin
          state_d    = rsf_pkg::RSF_HOLD;
          cnt_d      = 20'h0;
          holdLong_d = lowSupplyHit;
        end else begin
          cnt_d = cnt_q + 20'h1;
        end
      end
      rsf_pkg::RSF_HOLD: begin
        // A fresh low supply event restarts the long hold
        if (lowSupplyHit) begin
          cnt_d      = 20'h0;
          holdLong_d = 1'b1;
        end else if (cnt_q == holdLast) begin
          state_d = rsf_pkg::RSF_RUN;
        end else begin
          cnt_d = cnt_q + 20'h1;
        end
      end
    endcase
  end

  // Power-on starts in the long hold so every group initialises
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      state_q    <= rsf_pkg::RSF_HOLD;
      cnt_q      <= 20'h0;
      holdLong_q <= 1'b1;
    end else if (clkEn) begin
      state_q    <= state_d;
      cnt_q      <= cnt_d;
      holdLong_q <= holdLong_d;
    end
  end

  logic [3:0] flagSet;
  logic [3:0] flagClr;

  assign flagSet[rsf_pkg::FLAG_LOW_SUPPLY] = lowSupplyHit;
  assign flagSet[rsf_pkg::FLAG_BAD_VSEL]   = vselBad;
  assign flagSet[rsf_pkg::FLAG_CTRL_VALUE] = rctrlBad;
  assign flagSet[rsf_pkg::FLAG_WD_CTRL]    = watchdogCtrlFault;
  assign flagClr = wrFlags ? ~regWrData[3:0] : 4'h0;
  assign flags_d = (flags_q & ~flagClr) | flagSet;

  // Only the power-on reset reaches these flops
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      flags_q <= rsf_pkg::FLAGS_POR;
    end else if (clkEn) begin
      flags_q <= flags_d;
    end
  end

  // Undefined code reloads its power-on value
  assign vsel_d = vselBad ? rsf_pkg::VSEL_POR : (wrVsel ? regWrData : vsel_q);
  // Control value restored on non-warm resets
  assign rctrl_d = enterHold ? rsf_pkg::RCTRL_POR : (wrRctrl ? regWrData : rctrl_q);

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      vsel_q  <= rsf_pkg::VSEL_POR;
      rctrl_q <= rsf_pkg::RCTRL_POR;
    end else if (clkEn) begin
      vsel_q  <= vsel_d;
      rctrl_q <= rctrl_d;
    end
  end

  // Normal timeout sets expired flag only
  wire expiredSet = (running && wdtNormal && !lowSupplyHit && !pinReset) || warmHit;
  wire expired_d  = expiredSet | (expired_q & ~statusClear);
  // Warm timeout also sets power-down flag
  wire powerDown_d = warmHit | (powerDown_q & ~statusClear);

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      expired_q   <= 1'b0;
      powerDown_q <= 1'b0;
    end else if (clkEn) begin
      expired_q   <= expired_d;
      powerDown_q <= powerDown_d;
    end
  end

  // Warm timeout pulses only the PC and SP clears
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      warmPulse_q <= 1'b0;
      restart_q   <= 1'b0;
    end else if (clkEn) begin
      warmPulse_q <= warmHit;
      restart_q   <= holding && (state_d == rsf_pkg::RSF_RUN);
    end
  end

  wire [7:0] rdMux =
    (regAddr == rsf_pkg::ADDR_FLAGS)  ? {4'h0, flags_q} :
    (regAddr == rsf_pkg::ADDR_VSEL)   ? vsel_q :
    (regAddr == rsf_pkg::ADDR_RCTRL)  ? rctrl_q :
    // Status flags at bits 5 and 4
    (regAddr == rsf_pkg::ADDR_STATUS) ? {2'h0, expired_q, powerDown_q, 4'h0} :
    8'h00;

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      rdData_q <= 8'h00;
    end else if (clkEn) begin
      rdData_q <= regRead ? rdMux : 8'h00;
    end
  end

  assign regRdData           = rdData_q;
  assign resetPinSelected    = pinSelected;
  // Hold covers PC, interrupts, timers, ports, stack, pointers
  assign fullReset           = holding;
  // Every reset clears the PC low byte
  assign pcLowClear          = holding || warmPulse_q;
  assign stackPtrClear       = warmPulse_q;
  // Watchdog restarts as the hold ends
  assign wdtRestart          = restart_q;
  assign watchdogExpiredFlag = expired_q;
  assign powerDownFlag       = powerDown_q;

  default clocking rsfCk @(posedge clk);
  endclocking
  default disable iff (!arst_n);

  sequence warmEntry;
    clkEn && running && wdtWarm && !pinReset;
  endsequence

  sequence warmEffect;
    pcLowClear && stackPtrClear && !fullReset && watchdogExpiredFlag && powerDownFlag;
  endsequence

  a_upper_bits_zero: assert property (
    clkEn && regRead && regAddr == rsf_pkg::ADDR_FLAGS |=> regRdData[7:4] == 4'h0)
    else $error("flag register upper bits not zero");

  a_low_supply_flag: assert property (
    clkEn && lowSync_q[1] && !idleSleepMode |=> flags_q[2] && fullReset)
    else $error("low supply did not set flag and reset");

  a_flags_sticky: assert property (
    ((~flags_q & $past(flags_q)) != 4'h0) |->
      $past(clkEn && regWrite && regAddr == rsf_pkg::ADDR_FLAGS))
    else $error("flag dropped without software write");

  a_bad_vsel_flag: assert property (
    clkEn && vselBad |=> flags_q[1] && vsel_q == rsf_pkg::VSEL_POR)
    else $error("bad voltage code not flagged or reloaded");

  a_wdt_normal_reset: assert property (
    clkEn && running && wdtNormal && !lowSupplyHit && !pinReset |=>
      fullReset && watchdogExpiredFlag && $stable(powerDownFlag))
    else $error("normal watchdog timeout mishandled");

  a_wdt_warm_reset: assert property (
    warmEntry |=> warmEffect ##1 !stackPtrClear)
    else $error("warm watchdog timeout mishandled");

  a_ctrl_value_flag: assert property (
    clkEn && running && rctrlBad |=> flags_q[3] ##[1:20] (state_q != rsf_pkg::RSF_RUN))
    else $error("bad control value not flagged");

  a_hold_restores: assert property (
    $fell(fullReset) |-> rctrl_q == rsf_pkg::RCTRL_POR && wdtRestart)
    else $error("hold exit without restore and restart");

  a_status_hold: assert property (
    clkEn && running && pinReset && !statusClear |=>
      $stable(watchdogExpiredFlag) && $stable(powerDownFlag))
    else $error("pin reset changed status flags");

  a_restart_pulse: assert property (
    clkEn && wdtRestart |=> !wdtRestart)
    else $error("watchdog restart longer than one cycle");

  a_warm_keeps_ctrl: assert property (
    warmEntry ##0 !wrRctrl |=> $stable(rctrl_q))
    else $error("warm timeout changed control value");

  a_pin_keeps_flags: assert property (
    clkEn && running && pinReset && !wrFlags && (flagSet == 4'h0) |=> $stable(flags_q))
    else $error("pin reset changed reset flags");

  // Stack clear belongs to the warm path only
  a_hold_clears_pc: assert property (
    fullReset |-> pcLowClear && !stackPtrClear)
    else $error("hold without program counter clear");

  a_soft_delay_reset: assert property (
    clkEn && running && vselBad && !hardCause |=>
      (state_q == rsf_pkg::RSF_DELAY) ##[1:20] fullReset)
    else $error("bad voltage code did not reset");

endmodule : rsf_reset_flags

// [tb/rsf_reset_flags_tb.sv]
`timescale 1ns/100ps

module rsf_reset_flags_tb;
  localparam int LONG = 8;
  localparam int SHORT = 4;
  localparam int SRST = 8;
  logic       clk;
  logic       arst_n;
  logic       clkEn;
  logic [7:0] regAddr;
  logic [7:0] regWrData;
  logic       regWrite;
  logic       regRead;
  logic [7:0] regRdData;
  logic       pin_n;
  logic       lowSupplyReset;
  logic       watchdogTimeout;
  logic       watchdogCtrlFault;
  logic       idleSleepMode;
  logic       statusClear;
  logic       resetPinSelected;
  logic       fullReset;
  logic       pcLowClear;
  logic       stackPtrClear;
  logic       wdtRestart;
  logic       expired;
  logic       powerDown;
  int         failures;
  int         checks;
  logic [7:0] vcodes [4];

  rsf_reset_flags #(.LONG_HOLD_CYCLES(LONG), .SHORT_HOLD_CYCLES(SHORT),
    .SRESET_CYCLES(SRST)) dut_u (
    .clk(clk), .arst_n(arst_n), .clkEn(clkEn), .regAddr(regAddr),
    .regWrData(regWrData), .regWrite(regWrite), .regRead(regRead),
    .regRdData(regRdData), .externalResetPin_n(pin_n),
    .lowSupplyReset(lowSupplyReset), .watchdogTimeout(watchdogTimeout),
    .watchdogCtrlFault(watchdogCtrlFault), .idleSleepMode(idleSleepMode),
    .statusClear(statusClear), .resetPinSelected(resetPinSelected),
    .fullReset(fullReset), .pcLowClear(pcLowClear), .stackPtrClear(stackPtrClear),
    .wdtRestart(wdtRestart), .watchdogExpiredFlag(expired), .powerDownFlag(powerDown)
  );

  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  task automatic wrap_up();
    if (failures == 0 && checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : wrap_up

  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    checks++;
    if (got !== exp) begin
      failures++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    regAddr   <= a;
    regWrData <= d;
    regWrite  <= 1'b1;
    @(posedge clk);
    regWrite  <= 1'b0;
  endtask : wr

  task automatic rd(input string what, input logic [7:0] a, input logic [7:0] exp);
    @(posedge clk);
    regAddr <= a;
    regRead <= 1'b1;
    @(posedge clk);
    regRead <= 1'b0;
    @(negedge clk);
    chk(what, exp, regRdData);
  endtask : rd

  // Hold end bounded, restart pulse within two cycles of it
  task automatic wait_hold(input int lim);
    int   n;
    logic seen;
    n = 0;
    while (fullReset !== 1'b0 && n < lim) begin
      @(negedge clk);
      n++;
    end
    chk("holdEnd", 8'h00, {7'h0, fullReset});
    seen = wdtRestart;
    @(negedge clk);
    seen = seen | wdtRestart;
    chk("wdtRestart", 8'h01, {7'h0, seen});
  endtask : wait_hold

  task automatic expect_reset(input int lim1, input int lim2);
    int n;
    n = 0;
    @(negedge clk);
    while (fullReset !== 1'b1 && n < lim1) begin
      @(negedge clk);
      n++;
    end
    chk("fullReset", 8'h01, {7'h0, fullReset});
    wait_hold(lim2);
  endtask : expect_reset

  task automatic pulse_wdt(input logic sleep);
    @(posedge clk);
    idleSleepMode   <= sleep;
    watchdogTimeout <= 1'b1;
    @(posedge clk);
    watchdogTimeout <= 1'b0;
    @(negedge clk);
  endtask : pulse_wdt

  initial begin
    #300000;
    failures++;
    wrap_up();
  end

  initial begin
    vcodes = '{rsf_pkg::VSEL_LVL0, rsf_pkg::VSEL_LVL1, rsf_pkg::VSEL_LVL2, rsf_pkg::VSEL_LVL3};
    failures = 0;
    checks = 0;
    arst_n = 1'b0;
    clkEn = 1'b1;
    regAddr = 8'h00;
    regWrData = 8'h00;
    regWrite = 1'b0;
    regRead = 1'b0;
    pin_n = 1'b1;
    lowSupplyReset = 1'b0;
    watchdogTimeout = 1'b0;
    watchdogCtrlFault = 1'b0;
    idleSleepMode = 1'b0;
    statusClear = 1'b0;
    repeat (2) @(posedge clk);
    arst_n <= 1'b1;
    @(negedge clk);
    chk("pcLowClear", 8'h01, {7'h0, pcLowClear});
    chk("fullReset", 8'h01, {7'h0, fullReset});
    chk("pinSel", 8'h00, {7'h0, resetPinSelected});
    chk("stackPtrClear", 8'h00, {7'h0, stackPtrClear});
    expect_reset(2, LONG + 4);
    rd("flags", rsf_pkg::ADDR_FLAGS, 8'h00);
    rd("status", rsf_pkg::ADDR_STATUS, 8'h00);
    pulse_wdt(1'b1);
    chk("pcLowClear", 8'h01, {7'h0, pcLowClear});
    chk("stackPtrClear", 8'h01, {7'h0, stackPtrClear});
    chk("fullReset", 8'h00, {7'h0, fullReset});
    chk("expiredPd", 8'h03, {6'h0, expired, powerDown});
    @(negedge clk);
    chk("stackPtrClear", 8'h00, {7'h0, stackPtrClear});
    rd("status", rsf_pkg::ADDR_STATUS, 8'h30);
    rd("flags", rsf_pkg::ADDR_FLAGS, 8'h00);
    @(posedge clk);
    statusClear <= 1'b1;
    idleSleepMode <= 1'b0;
    @(posedge clk);
    statusClear <= 1'b0;
    rd("status", rsf_pkg::ADDR_STATUS, 8'h00);
    pulse_wdt(1'b0);
    chk("fullReset", 8'h01, {7'h0, fullReset});
    chk("pcLowClear", 8'h01, {7'h0, pcLowClear});
    chk("expiredPd", 8'h02, {6'h0, expired, powerDown});
    wait_hold(SHORT + 4);
    rd("status", rsf_pkg::ADDR_STATUS, 8'h20);
    rd("flags", rsf_pkg::ADDR_FLAGS, 8'h00);
    foreach (vcodes[i]) begin
      wr(rsf_pkg::ADDR_VSEL, vcodes[i]);
      rd("vsel", rsf_pkg::ADDR_VSEL, vcodes[i]);
      chk("fullReset", 8'h00, {7'h0, fullReset});
    end
    wr(rsf_pkg::ADDR_VSEL, 8'h12);
    rd("vsel", rsf_pkg::ADDR_VSEL, rsf_pkg::VSEL_POR);
    rd("flags", rsf_pkg::ADDR_FLAGS, 8'h02);
    expect_reset(SRST + 4, SHORT + 4);
    rd("flags", rsf_pkg::ADDR_FLAGS, 8'h02);
    wr(rsf_pkg::ADDR_FLAGS, 8'hff);
    rd("flags", rsf_pkg::ADDR_FLAGS, 8'h02);
    wr(rsf_pkg::ADDR_FLAGS, 8'h00);
    rd("flags", rsf_pkg::ADDR_FLAGS, 8'h00);
    wr(rsf_pkg::ADDR_RCTRL, 8'h0f);
    expect_reset(SRST + 4, SHORT + 4);
    rd("flags", rsf_pkg::ADDR_FLAGS, 8'h08);
    rd("rctrl", rsf_pkg::ADDR_RCTRL, rsf_pkg::RCTRL_POR);
    wr(rsf_pkg::ADDR_RCTRL, rsf_pkg::RCTRL_PIN);
    @(negedge clk);
    chk("pinSel", 8'h01, {7'h0, resetPinSelected});
    @(posedge clk);
    pin_n <= 1'b0;
    repeat (3) @(posedge clk);
    pin_n <= 1'b1;
    expect_reset(6, SHORT + 4);
    rd("flags", rsf_pkg::ADDR_FLAGS, 8'h08);
    chk("pinSel", 8'h00, {7'h0, resetPinSelected});
    @(posedge clk);
    watchdogCtrlFault <= 1'b1;
    @(posedge clk);
    watchdogCtrlFault <= 1'b0;
    expect_reset(SRST + 4, SHORT + 4);
    rd("flags", rsf_pkg::ADDR_FLAGS, 8'h09);
    @(posedge clk);
    lowSupplyReset <= 1'b1;
    repeat (4) @(posedge clk);
    lowSupplyReset <= 1'b0;
    expect_reset(6, LONG + 8);
    rd("flags", rsf_pkg::ADDR_FLAGS, 8'h0d);
    rd("status", rsf_pkg::ADDR_STATUS, 8'h20);
    @(posedge clk);
    clkEn <= 1'b0;
    wr(rsf_pkg::ADDR_FLAGS, 8'h00);
    clkEn <= 1'b1;
    rd("flags", rsf_pkg::ADDR_FLAGS, 8'h0d);
    @(posedge clk);
    arst_n <= 1'b0;
    repeat (2) @(posedge clk);
    arst_n <= 1'b1;
    expect_reset(2, LONG + 4);
    rd("flags", rsf_pkg::ADDR_FLAGS, 8'h00);
    rd("status", rsf_pkg::ADDR_STATUS, 8'h00);
    rd("vsel", rsf_pkg::ADDR_VSEL, rsf_pkg::VSEL_POR);
    wrap_up();
  end
endmodule : rsf_reset_flags_tb
